// >>> design/icrs_pkg.sv
/*
  Package for the two-wire configuration register slave: slave address,
  register map size, oversampling and timing constants, state and carrier types.
  Assumes a single 10 MHz system clock.
*/
package icrs_pkg;

  // ==========================================================================
  // addressing
  localparam logic [6:0] ICRS_SLAVE_ADDR = 7'h69;   // bus address of the device
  localparam int         ICRS_PTR_W      = 8;       // register pointer width
  localparam int         ICRS_DATA_W     = 8;       // register data width
  localparam int         ICRS_NUM_REGS   = 256;     // registers behind the pointer
  localparam logic [7:0] ICRS_REG_RESET  = 8'h00;   // default of every register
  localparam logic [7:0] ICRS_PTR_RESET  = 8'h00;   // pointer after power up

  // ==========================================================================
  // timing
  localparam int ICRS_CLK_HZ      = 10_000_000;
  localparam int ICRS_BUS_RATE    = 400_000;        // highest bus bit rate, bit/s
  localparam int ICRS_HIGH_NS     = 600;            // least clock high period
  localparam int ICRS_CLK_NS      = 1_000_000_000 / ICRS_CLK_HZ;
  // cycles in the shortest high phase, rounded down (least 1)
  localparam int ICRS_HIGH_CYC    = (ICRS_HIGH_NS / ICRS_CLK_NS) < 1 ? 1
                                    : (ICRS_HIGH_NS / ICRS_CLK_NS);
  localparam int ICRS_FILT_LEN    = 3;              // samples a level must hold

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ICRS_IDLE,
    ICRS_ADDR,
    ICRS_ADDR_ACK,
    ICRS_PTR,
    ICRS_WDATA,
    ICRS_WACK,
    ICRS_RDATA,
    ICRS_RACK
  } icrs_state_e;

  // filtered pin levels and edge events
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } icrs_line_s;

endpackage

// >>> design/icrs_slave.sv
/*
  Two-wire register slave for the clock generator configuration space.
  Assumes scl and sda inputs are synchronous to clock (sampled here again for
  safety) and that the pad combines sda_oe with an external pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module icrs_slave
  import icrs_pkg::*;
#(
  parameter int FILT_LEN = ICRS_FILT_LEN
) (
  // system
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // serial pins
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // register contents, pointer and busy flag seen by the clock generator core
  output logic [ICRS_NUM_REGS*ICRS_DATA_W-1:0] reg_flat,
  output logic [ICRS_PTR_W-1:0]       reg_ptr,
  output logic                        busy
);

  // ==========================================================================
  // pin synchroniser and filter
  logic [1:0]          scl_sync, sda_sync;
  logic [FILT_LEN-1:0] scl_hist, sda_hist;
  logic                scl_f, sda_f;
  logic [1:0]          next_scl_sync, next_sda_sync;
  logic [FILT_LEN-1:0] next_scl_hist, next_sda_hist;
  logic                next_scl_f, next_sda_f;
  icrs_line_s          line;

  // oversample and majority-free hold filter
  // hold depth stays under the shortest high phase at full rate
  always_comb begin
    next_scl_sync = {scl_sync[0], scl_in};
    next_sda_sync = {sda_sync[0], sda_in};
    next_scl_hist = {scl_hist[FILT_LEN-2:0], scl_sync[1]};
    next_sda_hist = {sda_hist[FILT_LEN-2:0], sda_sync[1]};
    next_scl_f    = scl_f;
    next_sda_f    = sda_f;
    if (&scl_hist) next_scl_f = 1'b1;
    if (~|scl_hist) next_scl_f = 1'b0;
    if (&sda_hist) next_sda_f = 1'b1;
    if (~|sda_hist) next_sda_f = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_hist <= '1;
      sda_hist <= '1;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_hist <= next_scl_hist;
      sda_hist <= next_sda_hist;
      scl_f    <= next_scl_f;
      sda_f    <= next_sda_f;
    end
  end

  // edge and condition decode on filtered levels
  logic scl_d, sda_d;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  always_comb begin
    line.scl      = scl_f;
    line.sda      = sda_f;
    line.scl_rise = scl_f & ~scl_d;
    line.scl_fall = ~scl_f & scl_d;
    line.start    = scl_f & scl_d & sda_d & ~sda_f;
    line.stop     = scl_f & scl_d & ~sda_d & sda_f;
  end

  // ==========================================================================
  // protocol engine
  icrs_state_e          state, next_state;
  logic [3:0]           bit_cnt, next_bit_cnt;
  logic [7:0]           shreg, next_shreg;
  logic [ICRS_PTR_W-1:0] ptr, next_ptr;
  logic                 drive_low, next_drive_low;
  logic                 wr_en, next_wr_en;
  logic [7:0]           wr_data, next_wr_data;
  logic [ICRS_DATA_W-1:0] regs [ICRS_NUM_REGS];

  // byte at a pointer value
  function automatic logic [7:0] reg_at(input logic [ICRS_PTR_W-1:0] p);
    reg_at = reg_flat[p*ICRS_DATA_W +: ICRS_DATA_W];
  endfunction

  // byte under the pointer, loaded into the shifter at each read start
  logic [7:0] cur_byte;
  always_comb begin
    cur_byte = reg_at(ptr);
  end

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_ptr       = ptr;
    next_drive_low = drive_low;
    next_wr_en     = 1'b0;
    next_wr_data   = wr_data;
    if (line.start) begin
      next_state     = ICRS_ADDR;
      next_bit_cnt   = 4'h0;
      next_drive_low = 1'b0;
    end else if (line.stop) begin
      next_state     = ICRS_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        ICRS_IDLE: begin
          next_drive_low = 1'b0;
        end
        ICRS_ADDR, ICRS_PTR, ICRS_WDATA: begin
          if (line.scl_rise) begin
            next_shreg   = {shreg[6:0], line.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (line.scl_fall && bit_cnt == 4'h8) begin
            next_bit_cnt = 4'h0;
            if (state == ICRS_ADDR) begin
              if (shreg[7:1] == ICRS_SLAVE_ADDR) begin
                next_state     = ICRS_ADDR_ACK;
                next_drive_low = 1'b1;
              end else begin
                next_state = ICRS_IDLE;
              end
            end else begin
              next_state     = ICRS_WACK;
              next_drive_low = 1'b1;
              if (state == ICRS_PTR) begin
                next_ptr = shreg;
              end else begin
                next_wr_en   = 1'b1;
                next_wr_data = shreg;
                next_ptr     = ptr + 8'h01;
              end
            end
          end
        end
        ICRS_ADDR_ACK, ICRS_WACK: begin
          if (line.scl_fall) begin
            if (state == ICRS_ADDR_ACK && shreg[0]) begin
              next_state     = ICRS_RDATA;
              next_shreg     = cur_byte;
              next_drive_low = ~cur_byte[7];
              next_bit_cnt   = 4'h1;
            end else begin
              next_state     = (state == ICRS_ADDR_ACK) ? ICRS_PTR : ICRS_WDATA;
              next_drive_low = 1'b0;
            end
          end
        end
        ICRS_RDATA: begin
          if (line.scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_state     = ICRS_RACK;
              next_drive_low = 1'b0;
              next_ptr       = ptr + 8'h01;
            end else begin
              next_shreg     = {shreg[6:0], 1'b0};
              next_drive_low = ~shreg[6];
              next_bit_cnt   = bit_cnt + 4'h1;
            end
          end
        end
        ICRS_RACK: begin
          if (line.scl_rise) begin
            next_shreg[0] = line.sda;
          end
          if (line.scl_fall) begin
            if (!shreg[0]) begin
              next_state     = ICRS_RDATA;
              next_shreg     = cur_byte;
              next_drive_low = ~cur_byte[7];
              next_bit_cnt   = 4'h1;
            end else begin
              next_state = ICRS_IDLE;
            end
          end
        end
        default: begin
          next_state     = ICRS_IDLE;
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state     <= ICRS_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      ptr       <= ICRS_PTR_RESET;
      drive_low <= 1'b0;
      wr_en     <= 1'b0;
      wr_data   <= 8'h00;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      ptr       <= next_ptr;
      drive_low <= next_drive_low;
      wr_en     <= next_wr_en;
      wr_data   <= next_wr_data;
    end
  end

  // ==========================================================================
  // register array; pointer advances first, write lands at the old pointer a cycle later
  logic [ICRS_PTR_W-1:0] wr_ptr;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr <= ICRS_PTR_RESET;
      for (int i = 0; i < ICRS_NUM_REGS; i++) begin
        regs[i] <= ICRS_REG_RESET;
      end
    end else begin
      wr_ptr <= ptr;  // one cycle behind ptr: the slot of the byte in flight
      if (wr_en) begin
        regs[wr_ptr] <= wr_data;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < ICRS_NUM_REGS; i++) begin
      reg_flat[i*ICRS_DATA_W +: ICRS_DATA_W] = regs[i];
    end
  end

  // outputs
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;
  assign reg_ptr = ptr;
  assign busy    = (state != ICRS_IDLE);

  // ==========================================================================
  // checks
  a_stop_release: assert property (@(posedge clock) disable iff (sys_rst)
    line.stop |=> !sda_oe) else $error("sda still driven after stop");
  a_nomatch_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ICRS_IDLE) |-> !sda_oe) else $error("sda driven while idle");
  a_addr_ack: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ICRS_ADDR && line.scl_fall && bit_cnt == 4'h8 && !line.start && !line.stop
     && shreg[7:1] == ICRS_SLAVE_ADDR) |=> sda_oe) else $error("own address not acked");
  a_wrap_ptr: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ICRS_RDATA && next_state == ICRS_RACK) |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance");
  a_sda_change: assert property (@(posedge clock) disable iff (sys_rst)
    (line.scl && scl_d && $changed(sda_oe)) |-> $past(line.start || line.stop))
    else $error("sda changed while scl high");
  a_write_store: assert property (@(posedge clock) disable iff (sys_rst)
    wr_en |=> regs[$past(wr_ptr)] == $past(wr_data)) else $error("byte not stored");
  a_start_frame: assert property (@(posedge clock) disable iff (sys_rst)
    line.start |=> state == ICRS_ADDR && bit_cnt == 4'h0) else $error("start ignored");
  a_wack_drive: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ICRS_WACK) |-> sda_oe) else $error("write byte not acked");
  a_write_ptr: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ICRS_WDATA && next_state == ICRS_WACK) |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance after write");
  a_ptr_load: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ICRS_PTR && next_state == ICRS_WACK) |=> ptr == $past(shreg))
    else $error("pointer byte not loaded");
  a_read_nack: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ICRS_RACK && line.scl_fall && shreg[0]) |=> state == ICRS_IDLE && !sda_oe)
    else $error("read not ended on nack");
  a_filter_hold: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(scl_f) |-> $past(&scl_hist || ~|scl_hist))
    else $error("scl level passed filter early");

endmodule
`default_nettype wire

// >>> dv/icrs_bus_master.sv
/*
  Bus master model for the two-wire register slave: start, stop, byte write
  and byte read with acknowledge. Assumes the bench resolves sda with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module icrs_bus_master #(
  parameter int HALF = 15
) (
  // system
  input  wire logic clock,
  // bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ==========================================================================
  int half;  // clock cycles in the scl high phase; the low phase lasts 4 cycles more

  // bus idle: both lines released high
  initial begin
    half    = HALF;
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // change the bit rate between frames
  task automatic set_half(input int h);
    half = h;
  endtask

  task automatic wait_half();
    repeat (half) @(negedge clock);
  endtask

  // start or repeated start, sda falls while scl high
  task automatic start();
    sda_low = 1'b0;
    wait_half();
    scl = 1'b1;
    wait_half();
    sda_low = 1'b1;
    wait_half();
    scl = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // stop, sda rises while scl high; lines left released
  task automatic stop();
    sda_low = 1'b1;
    wait_half();
    scl = 1'b1;
    wait_half();
    sda_low = 1'b0;
    wait_half();
  endtask

  // one bit: data set while scl low, sampled at end of high phase
  task automatic bit_xfer(input logic b, output logic r);
    sda_low = ~b;
    wait_half();
    scl = 1'b1;
    wait_half();
    r   = sda;
    scl = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // byte sent msb first, then ninth clock with sda released
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // byte read msb first; last byte is not acknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, r);
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
/*
  Self-checking bench for the two-wire register slave.
  Assumes the master model drives scl and pulls sda low through sda_low.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import icrs_pkg::*;
  // ==========================================================================
  // clock, reset and bus wiring
  logic                                 clock;
  logic                                 sys_rst;
  logic                                 scl;
  logic                                 sda_low;
  logic                                 sda_out;
  logic                                 sda_oe;
  logic [ICRS_NUM_REGS*ICRS_DATA_W-1:0] reg_flat;
  logic [ICRS_PTR_W-1:0]                reg_ptr;
  logic                                 busy;
  wire logic                            sda;
  int                                   mismatches;
  int                                   checks_done;
  int                                   cycles;

  // pull-up wins unless someone pulls low
  assign sda = ((sda_oe && !sda_out) || sda_low) ? 1'b0 : 1'b1;

  icrs_slave uut (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_flat(reg_flat),
    .reg_ptr(reg_ptr), .busy(busy)
  );

  icrs_bus_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ==========================================================================
  // checking and closing
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] rg(input int n);
    return reg_flat[8*n +: 8];
  endfunction

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic a;
    m.start();
    m.wbyte(8'hD2, a);
    chk("addr ack", 8'h01, {7'h00, a});
    m.wbyte(ptr, a);
    chk("ptr ack", 8'h01, {7'h00, a});
    chk("busy", 8'h01, {7'h00, busy});
    foreach (d[i]) begin
      m.wbyte(d[i], a);
      chk("data ack", 8'h01, {7'h00, a});
    end
    m.stop();
  endtask

  task automatic test_reset();
    chk("ptr", 8'h00, reg_ptr);
    chk("busy", 8'h00, {7'h00, busy});
    chk("reg 10", 8'h00, rg(16));
    chk("sda_out", 8'h00, {7'h00, sda_out});
  endtask

  task automatic test_single_write();
    write_regs(8'h10, '{8'hA5});
    chk("reg 10", 8'hA5, rg(16));
    chk("ptr", 8'h11, reg_ptr);
    chk("busy", 8'h00, {7'h00, busy});
  endtask

  task automatic test_wrap_write();
    write_regs(8'hFE, '{8'h11, 8'h22, 8'h33, 8'h44});
    chk("reg FE", 8'h11, rg(254));
    chk("reg FF", 8'h22, rg(255));
    chk("reg 00", 8'h33, rg(0));
    chk("reg 01", 8'h44, rg(1));
    chk("ptr", 8'h02, reg_ptr);
  endtask

  task automatic test_wrong_addr();
    logic a;
    m.start();
    m.wbyte(8'hD0, a);
    chk("foreign ack", 8'h00, {7'h00, a});
    m.wbyte(8'h10, a);
    chk("ignored ack", 8'h00, {7'h00, a});
    m.wbyte(8'h5A, a);
    m.stop();
    chk("reg 10", 8'hA5, rg(16));
    chk("ptr", 8'h02, reg_ptr);
  endtask

  task automatic test_reads();
    logic       a;
    logic [7:0] d;
    m.start();
    m.wbyte(8'hD2, a);
    m.wbyte(8'hFE, a);
    m.start();
    m.wbyte(8'hD3, a);
    chk("read ack", 8'h01, {7'h00, a});
    m.rbyte(1'b0, d);
    chk("rd FE", 8'h11, d);
    m.rbyte(1'b0, d);
    chk("rd FF", 8'h22, d);
    m.rbyte(1'b1, d);
    chk("rd 00", 8'h33, d);
    m.stop();
    chk("oe", 8'h00, {7'h00, sda_oe});
    chk("ptr", 8'h01, reg_ptr);
    chk("reg FE", 8'h11, rg(254));
    m.start();
    m.wbyte(8'hD3, a);
    m.rbyte(1'b1, d);
    m.stop();
    chk("rd cur", 8'h44, d);
    chk("ptr", 8'h02, reg_ptr);
  endtask

  // nearest bit rate at or below the highest allowed one
  task automatic test_fast();
    logic       a;
    logic [7:0] d;
    m.set_half((ICRS_CLK_HZ / ICRS_BUS_RATE - 3) / 2);
    write_regs(8'h40, '{8'h5C, 8'hC5});
    chk("reg 40", 8'h5C, rg(64));
    chk("reg 41", 8'hC5, rg(65));
    m.start();
    m.wbyte(8'hD2, a);
    m.wbyte(8'h40, a);
    m.start();
    m.wbyte(8'hD3, a);
    m.rbyte(1'b0, d);
    chk("rd 40", 8'h5C, d);
    m.rbyte(1'b1, d);
    chk("rd 41", 8'hC5, d);
    m.stop();
  endtask

  // reset in mid-run returns registers and pointer to defaults
  task automatic test_rerun_reset();
    logic       a;
    logic [7:0] d;
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (10) @(negedge clock);
    chk("ptr", 8'h00, reg_ptr);
    chk("reg 40", 8'h00, rg(64));
    m.start();
    m.wbyte(8'hD3, a);
    m.rbyte(1'b1, d);
    m.stop();
    chk("rd 00", 8'h00, d);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    sys_rst     = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (10) @(negedge clock);
    test_reset();
    test_single_write();
    test_wrap_write();
    test_wrong_addr();
    test_reads();
    test_fast();
    test_rerun_reset();
    conclude();
  end
endmodule
`default_nettype wire
